// File: rtl/bnvr_host.sv
// Purpose: host controller driving the bytewide nonvolatile RAM pins
// Assumes: one 10 MHz clock, synchronous pins, chip select raised per access
// Notes:   one access per read or write request; protection change runs as a ten-step script
`timescale 1ns/1ps
`default_nettype none
module bnvr_host
    import bnvr_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic                        req_valid,
    input  wire bnvr_pkg::bnvr_cmd_t         req_cmd,
    input  wire logic [bnvr_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [bnvr_pkg::DATA_W-1:0] req_wdata,
    output logic                             req_ready,
    output logic                             rsp_valid,
    output logic [bnvr_pkg::DATA_W-1:0]      rsp_rdata,
    output logic                             locked_out,
    output logic                             chip_sel_n,
    output logic                             write_strobe_n,
    output logic                             out_drive_n,
    output logic [bnvr_pkg::ADDR_W-1:0]      mem_addr,
    output logic [bnvr_pkg::DATA_W-1:0]      dq_out,
    output logic                             dq_oe,
    input  wire logic [bnvr_pkg::DATA_W-1:0] dq_in,
    input  wire logic                        low_supply_lockout_n
);
    import bnvr_pkg::*;

    bnvr_state_t         state, next_state;
    logic [CNT_W-1:0]    cnt, next_cnt;
    logic                is_write, next_is_write;
    logic                in_prot, next_in_prot;
    logic [3:0]          step, next_step;
    logic [DATA_W-1:0]   prot_byte, next_prot_byte;
    logic                next_req_ready, next_rsp_valid, next_locked_out;
    logic                next_chip_sel_n, next_write_strobe_n, next_out_drive_n;
    logic [ADDR_W-1:0]   next_mem_addr;
    logic [DATA_W-1:0]   next_dq_out, next_rsp_rdata;
    logic                next_dq_oe;
    logic [ADDR_W:0]     next_access;

    // script for the protection change, one access per step
    function automatic logic [ADDR_W:0] prot_step(input logic [3:0] s);
        unique case (s)
            4'h0:    prot_step = {1'b0, UNLOCK_A0};
            4'h1:    prot_step = {1'b0, UNLOCK_A1};
            4'h2:    prot_step = {1'b0, UNLOCK_A2};
            4'h3:    prot_step = {1'b0, UNLOCK_A3};
            4'h4:    prot_step = {1'b0, UNLOCK_A4};
            4'h5:    prot_step = {1'b0, UNLOCK_A5};
            4'h6:    prot_step = {1'b1, PROT_WA};
            4'h7:    prot_step = {1'b1, PROT_WB};
            4'h8:    prot_step = {1'b1, FINISH_WA};
            default: prot_step = {1'b0, RESET_RA};
        endcase
    endfunction

    // script entry for the step after the current one
    assign next_access = prot_step(step + 4'h1);

    always_comb begin
        next_state          = state;
        next_cnt            = cnt;
        next_is_write       = is_write;
        next_in_prot        = in_prot;
        next_step           = step;
        next_prot_byte      = prot_byte;
        next_rsp_valid      = 1'b0;
        next_rsp_rdata      = rsp_rdata;
        next_chip_sel_n     = chip_sel_n;
        next_write_strobe_n = write_strobe_n;
        next_out_drive_n    = out_drive_n;
        next_mem_addr       = mem_addr;
        next_dq_out         = dq_out;
        next_dq_oe          = dq_oe;
        next_locked_out     = !low_supply_lockout_n;
        next_req_ready      = 1'b0;
        unique case (state)
            ST_IDLE: begin
                next_req_ready = low_supply_lockout_n;
                if (req_valid && req_ready && low_supply_lockout_n) begin
                    next_req_ready = 1'b0;
                    next_in_prot   = (req_cmd == CMD_PROT);
                    next_step      = 4'h0;
                    next_prot_byte = req_wdata;
                    next_state     = ST_SETUP;
                    if (req_cmd == CMD_PROT) begin
                        // script starts at first unlock read
                        next_mem_addr = UNLOCK_A0;
                        next_is_write = 1'b0;
                    end else begin
                        next_mem_addr = req_addr;
                        next_is_write = (req_cmd == CMD_WRITE);
                        next_dq_out   = req_wdata;
                        // strobe and data lead select
                        // same-edge strobe and select would leave the cycle kind ambiguous
                        next_write_strobe_n = (req_cmd != CMD_WRITE);
                        next_dq_oe          = (req_cmd == CMD_WRITE);
                    end
                end
            end
            ST_SETUP: begin
                // address stable before chip select falls
                next_chip_sel_n  = 1'b0;
                next_out_drive_n = is_write;
                // strobe low before select means write cycle
                next_write_strobe_n = !is_write;
                next_dq_oe       = is_write;
                next_cnt         = CNT_W'(RANDOM_CYCLE_MIN_CYC);
                next_state       = ST_ACCESS;
            end
            ST_ACCESS: begin
                if (cnt > CNT_W'(1)) begin
                    next_cnt = cnt - CNT_W'(1);
                end else begin
                    // data still driven as select rises
                    next_chip_sel_n     = 1'b1;
                    next_write_strobe_n = 1'b1;
                    next_out_drive_n    = 1'b1;
                    next_rsp_rdata      = is_write ? rsp_rdata : dq_in;
                    next_state          = ST_HOLD;
                end
            end
            ST_HOLD: begin
                next_dq_oe = 1'b0;
                next_cnt   = CNT_W'(PRECHARGE_MIN_CYC - 1);
                next_state = ST_PRECH;
            end
            ST_PRECH: begin
                if (cnt > CNT_W'(1)) begin
                    next_cnt = cnt - CNT_W'(1);
                end else if (in_prot && step != PROT_STEPS - 4'h1) begin
                    // script continues through finish write and read
                    next_step     = step + 4'h1;
                    next_is_write = next_access[ADDR_W];
                    next_mem_addr = next_access[ADDR_W-1:0];
                    next_write_strobe_n = !(low_supply_lockout_n && next_access[ADDR_W]);
                    next_dq_oe          = low_supply_lockout_n && next_access[ADDR_W];
                    next_dq_out   = (step + 4'h1 == 4'h7) ? ~prot_byte : prot_byte;
                    next_state    = low_supply_lockout_n ? ST_SETUP : ST_IDLE;
                end else begin
                    next_rsp_valid = 1'b1;
                    next_in_prot   = 1'b0;
                    next_state     = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state          <= ST_IDLE;
            cnt            <= '0;
            is_write       <= 1'b0;
            in_prot        <= 1'b0;
            step           <= 4'h0;
            prot_byte      <= 8'h00;
            req_ready      <= 1'b0;
            rsp_valid      <= 1'b0;
            rsp_rdata      <= 8'h00;
            locked_out     <= 1'b1;
            chip_sel_n     <= 1'b1;
            write_strobe_n <= 1'b1;
            out_drive_n    <= 1'b1;
            mem_addr       <= '0;
            dq_out         <= 8'h00;
            dq_oe          <= 1'b0;
        end else begin
            state          <= next_state;
            cnt            <= next_cnt;
            is_write       <= next_is_write;
            in_prot        <= next_in_prot;
            step           <= next_step;
            prot_byte      <= next_prot_byte;
            req_ready      <= next_req_ready;
            rsp_valid      <= next_rsp_valid;
            rsp_rdata      <= next_rsp_rdata;
            locked_out     <= next_locked_out;
            chip_sel_n     <= next_chip_sel_n;
            write_strobe_n <= next_write_strobe_n;
            out_drive_n    <= next_out_drive_n;
            mem_addr       <= next_mem_addr;
            dq_out         <= next_dq_out;
            dq_oe          <= next_dq_oe;
        end
    end

    // helper: cycles since chip select rose
    logic [CNT_W-1:0] high_cnt;
    always_ff @(posedge clk) begin
        if (reset) begin
            high_cnt <= '1;
        end else if (!chip_sel_n) begin
            high_cnt <= '0;
        end else if (high_cnt != '1) begin
            high_cnt <= high_cnt + CNT_W'(1);
        end
    end

    precharge_gap_a: assert property (@(posedge clk) disable iff (reset)
        $fell(chip_sel_n) |-> $past(high_cnt) >= CNT_W'(PRECHARGE_MIN_CYC))
        else $error("chip select high shorter than precharge");
    cycle_len_a: assert property (@(posedge clk) disable iff (reset)
        $fell(chip_sel_n) |-> !chip_sel_n [*4])
        else $error("select low shorter than random cycle");
    no_contention_a: assert property (@(posedge clk) disable iff (reset)
        dq_oe |-> out_drive_n)
        else $error("host drives while output drive low");
    write_data_a: assert property (@(posedge clk) disable iff (reset)
        ($rose(chip_sel_n) && $past(!write_strobe_n)) |-> dq_oe && $stable(dq_out))
        else $error("write data not held at select rise");
    strobe_toggle_a: assert property (@(posedge clk) disable iff (reset)
        $fell(write_strobe_n) |=> !write_strobe_n [*2])
        else $error("write strobe pulse too short");
    setup_time_a: assert property (@(posedge clk) disable iff (reset)
        $rose(chip_sel_n) && dq_oe |-> $past(dq_oe, 2) && $past(dq_out, 2) == dq_out)
        else $error("write data setup violated");
    lockout_block_a: assert property (@(posedge clk) disable iff (reset)
        locked_out |-> !req_ready)
        else $error("request accepted during lockout");
    prot_complement_a: assert property (@(posedge clk) disable iff (reset)
        (in_prot && step == 4'h7 && $fell(chip_sel_n)) |-> dq_out == ~prot_byte)
        else $error("protection confirm not complement");
    unlock_order_a: assert property (@(posedge clk) disable iff (reset)
        (in_prot && step == 4'h0 && $fell(chip_sel_n)) |-> mem_addr == UNLOCK_A0)
        else $error("unlock sequence not started at first address");
endmodule
`default_nettype wire

// File: rtl/bnvr_pkg.sv
// Purpose: constants for the host-side controller of the bytewide nonvolatile RAM
// Assumes: 10 MHz clock, 100 ns period
// Notes:   Functional notes below
package bnvr_pkg;
    localparam int CLK_PERIOD_NS        = 100;
    localparam int ADDR_W               = 17;
    localparam int DATA_W               = 8;
    localparam int COL_W                = 3;
    // timing figures in ns as specified
    localparam int RANDOM_CYCLE_MIN_NS  = 350;
    localparam int PRECHARGE_MIN_NS     = 290;
    localparam int ACCESS_TIME_NS       = 60;
    localparam int PAGE_ACCESS_NS       = 25;
    localparam int SETUP_NS             = 60;
    // least times round up
    localparam int RANDOM_CYCLE_MIN_CYC = (RANDOM_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRECHARGE_MIN_CYC    = (PRECHARGE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC           = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAGE_ACCESS_CYC      = (PAGE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC            = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W                = 4;
    // unlock and finishing addresses
    localparam logic [ADDR_W-1:0] UNLOCK_A0 = 17'h05555;
    localparam logic [ADDR_W-1:0] UNLOCK_A1 = 17'h1aaaa;
    localparam logic [ADDR_W-1:0] UNLOCK_A2 = 17'h03333;
    localparam logic [ADDR_W-1:0] UNLOCK_A3 = 17'h1cccc;
    localparam logic [ADDR_W-1:0] UNLOCK_A4 = 17'h100ff;
    localparam logic [ADDR_W-1:0] UNLOCK_A5 = 17'h0ff00;
    localparam logic [ADDR_W-1:0] PROT_WA   = 17'h1aaaa;
    localparam logic [ADDR_W-1:0] PROT_WB   = 17'h1cccc;
    localparam logic [ADDR_W-1:0] FINISH_WA = 17'h0ff00;
    localparam logic [ADDR_W-1:0] RESET_RA  = 17'h00000;
    localparam logic [3:0]        PROT_STEPS = 4'ha;

    typedef enum logic [1:0] {
        CMD_READ  = 2'h0,
        CMD_WRITE = 2'h1,
        CMD_PROT  = 2'h2
    } bnvr_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_ACCESS = 3'b011,
        ST_HOLD   = 3'b010,
        ST_PRECH  = 3'b110
    } bnvr_state_t;
endpackage

// File: tb/bnvr_dev_model.sv
// Purpose: behavioural model of the bytewide nonvolatile RAM at the pins
// Assumes: pins change on the host's clock; delays in ns
// Notes:   counts host timing slips in viol; page mode reads modelled on column change
`timescale 1ns/1ps
`default_nettype none
module bnvr_dev_model
    import bnvr_pkg::*;
#(
    parameter int HOLDOFF_NS = 2000
)(
    input  wire logic                        chip_sel_n,
    input  wire logic                        write_strobe_n,
    input  wire logic                        out_drive_n,
    input  wire logic [bnvr_pkg::ADDR_W-1:0] mem_addr,
    input  wire logic [bnvr_pkg::DATA_W-1:0] dq_bus,
    input  wire logic                        host_drv,
    input  wire logic                        supply_ok,
    output logic [bnvr_pkg::DATA_W-1:0]      dev_q,
    output logic                             dev_en,
    output logic                             low_supply_lockout_n,
    output logic [7:0]                       viol
);
    import bnvr_pkg::*;
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [ADDR_W-1:0] seq [6];
    logic [7:0]        prot;
    logic [7:0]        pend;
    logic [ADDR_W-1:0] lat;
    logic              wr;
    logic              valid;
    int                step;
    realtime           t_rise;
    realtime           t_fall;
    initial begin
        for (int i = 0; i < (1 << ADDR_W); i++) mem[i] = 8'h00;
        seq = '{UNLOCK_A0, UNLOCK_A1, UNLOCK_A2, UNLOCK_A3, UNLOCK_A4, UNLOCK_A5};
        prot = 8'h00;
        step = 0;
        viol = 8'h00;
        wr = 1'b0;
        valid = 1'b0;
        dev_q = 8'h00;
        t_rise = -1000.0;
        t_fall = -1000.0;
        low_supply_lockout_n = 1'b0;
    end
    always @(negedge chip_sel_n) begin
        if ($realtime - t_rise < PRECHARGE_MIN_NS || $realtime - t_fall < RANDOM_CYCLE_MIN_NS)
            viol = viol + 8'h01;
        t_fall = $realtime;
        lat = mem_addr;
        wr = !write_strobe_n;
        valid = 1'b0;
        if (!wr && low_supply_lockout_n) begin
            if (step < 6 && lat == seq[step]) step++;
            else step = (lat == seq[0]) ? 1 : 0;
            #ACCESS_TIME_NS;
            dev_q = mem[lat];
            valid = !chip_sel_n;
        end
    end
    // strobe under select: write, new column
    always @(negedge write_strobe_n) begin
        if (!chip_sel_n) begin
            wr = 1'b1;
            lat[COL_W-1:0] = mem_addr[COL_W-1:0];
        end
    end
    // column change keeps the row open
    always @(mem_addr) begin
        if (!chip_sel_n && !wr && mem_addr[ADDR_W-1:COL_W] == lat[ADDR_W-1:COL_W]) begin
            lat[COL_W-1:0] = mem_addr[COL_W-1:0];
            #PAGE_ACCESS_NS;
            dev_q = mem[lat];
        end
    end
    always @(posedge chip_sel_n or posedge write_strobe_n) begin
        if (wr && low_supply_lockout_n) begin
            if (!host_drv) viol = viol + 8'h01;
            if (step == 6) begin
                pend = dq_bus;
                step = 7;
            end else if (step == 7) begin
                if (dq_bus == ~pend) prot = pend;
                step = 0;
            end else begin
                if (!prot[lat[16:14]]) mem[lat] = dq_bus;
                step = 0;
            end
        end
        wr = 1'b0;
        if (chip_sel_n) begin
            valid = 1'b0;
            t_rise = $realtime;
        end
    end
    // drive only when valid and enabled
    assign dev_en = !chip_sel_n && !out_drive_n && write_strobe_n && valid && !wr;
    always @(negedge supply_ok) low_supply_lockout_n = 1'b0;
    always @(posedge supply_ok) begin
        #HOLDOFF_NS;
        low_supply_lockout_n = supply_ok;
    end
endmodule
`default_nettype wire

// File: tb/bnvr_host_tb.sv
// Purpose: self-checking bench of the host controller against the device model
// Assumes: inputs driven at falling clock edge
// Notes:   undriven data bus shows the inverse of the last device byte
`timescale 1ns/1ps
`default_nettype none
module bnvr_host_tb;
    import bnvr_pkg::*;
    logic clk, reset, req_valid, req_ready, rsp_valid, locked_out, supply_ok;
    logic cs_n, we_n, oe_n, dq_oe, dev_en, lock_n;
    bnvr_cmd_t req_cmd;
    logic [ADDR_W-1:0] req_addr, mem_addr;
    logic [DATA_W-1:0] req_wdata, rsp_rdata, dq_out, dq_in, dev_q;
    logic [7:0] viol;
    int n_mismatch, n_tests, cyc;
    assign dq_in = dq_oe ? dq_out : (dev_en ? dev_q : ~dev_q);
    bnvr_host dut (.clk(clk), .reset(reset), .req_valid(req_valid), .req_cmd(req_cmd),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .locked_out(locked_out),
        .chip_sel_n(cs_n), .write_strobe_n(we_n), .out_drive_n(oe_n), .mem_addr(mem_addr),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .low_supply_lockout_n(lock_n));
    bnvr_dev_model #(.HOLDOFF_NS(2000)) dev (.chip_sel_n(cs_n), .write_strobe_n(we_n),
        .out_drive_n(oe_n), .mem_addr(mem_addr), .dq_bus(dq_in), .host_drv(dq_oe),
        .supply_ok(supply_ok), .dev_q(dev_q), .dev_en(dev_en),
        .low_supply_lockout_n(lock_n), .viol(viol));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one request, waits for answer; returns read byte
    task automatic do_req(input bnvr_cmd_t c, input logic [16:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        req_cmd = c;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        check(n < 300, 1);
        q = rsp_rdata;
        @(negedge clk);
    endtask
    task automatic t_power;
        check(locked_out, 1);
        check(req_ready, 0);
        supply_ok = 1'b1;
        repeat (15) @(negedge clk);
        check(locked_out, 1);
        repeat (10) @(negedge clk);
        check(locked_out, 0);
        check(req_ready, 1);
        $display("test power done");
    endtask
    task automatic t_rdwr;
        logic [16:0] a [4] = '{17'h00000, 17'h1ffff, 17'h00007, 17'h00008};
        logic [7:0] q;
        for (int i = 0; i < 4; i++) do_req(CMD_WRITE, a[i], 8'h3c ^ 8'(i * 17), q);
        for (int i = 0; i < 4; i++) begin
            do_req(CMD_READ, a[i], 8'h00, q);
            check(q, 8'h3c ^ 8'(i * 17));
        end
        $display("test read write done");
    endtask
    task automatic t_prot;
        logic [16:0] a [3] = '{17'h00010, 17'h10010, 17'h08010};
        logic [7:0] q;
        for (int i = 0; i < 3; i++) do_req(CMD_WRITE, a[i], 8'h11 * 8'(i + 1), q);
        do_req(CMD_PROT, 17'h00000, 8'h13, q);
        check(q, 8'h3c);
        do_req(CMD_READ, PROT_WA, 8'h00, q);
        check(q, 8'h00);
        for (int i = 0; i < 3; i++) do_req(CMD_WRITE, a[i], 8'hc0 + 8'(i), q);
        do_req(CMD_READ, a[0], 8'h00, q);
        check(q, 8'h11);
        do_req(CMD_READ, a[1], 8'h00, q);
        check(q, 8'h22);
        do_req(CMD_READ, a[2], 8'h00, q);
        check(q, 8'hc2);
        do_req(CMD_PROT, 17'h00000, 8'h00, q);
        check(q, 8'h3c);
        do_req(CMD_WRITE, a[0], 8'h5a, q);
        do_req(CMD_READ, a[0], 8'h00, q);
        check(q, 8'h5a);
        $display("test protection done");
    endtask
    task automatic t_lock;
        supply_ok = 1'b0;
        repeat (2) @(negedge clk);
        check(locked_out, 1);
        check(req_ready, 0);
        check(viol, 0);
        supply_ok = 1'b1;
        repeat (30) @(negedge clk);
        check(req_ready, 1);
        $display("test lockout done");
    endtask
    always @(negedge clk) if (!reset && dq_oe === 1'b1 && dev_en === 1'b1) check(1, 0);
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        n_mismatch = 0;
        n_tests = 0;
        cyc = 0;
        reset = 1'b1;
        supply_ok = 1'b0;
        req_valid = 1'b0;
        req_cmd = CMD_READ;
        req_addr = 17'h00000;
        req_wdata = 8'h00;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        t_power();
        t_rdwr();
        t_prot();
        t_lock();
        tally_and_finish();
    end
endmodule
`default_nettype wire
